// ---- bench/io_host.sv ----
// processor side of the four-port bus: timed read and write strobes
module io_host (
  input wire logic clock,
  output logic [7:0] addr,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic [7:0] select_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr = 8'h00;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 8'h00;
  end

  // strobes held four cycles each way; sync plus select take three edges
  task automatic io_write(input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] sel);
    @(negedge clock);
    addr = a;
    data_in = d;
    wr_n = 1'b0;
    repeat (4) @(negedge clock);
    sel = select_n;
    wr_n = 1'b1;
    // released lines show the inverse so stale values are never trusted
    addr = ~a;
    data_in = ~d;
    repeat (4) @(negedge clock);
  endtask : io_write

  task automatic io_read(input logic [7:0] a, output logic [7:0] d,
                         output logic [7:0] sel, output logic oe);
    @(negedge clock);
    addr = a;
    rd_n = 1'b0;
    repeat (4) @(negedge clock);
    d = data_out;
    sel = select_n;
    oe = data_oe;
    rd_n = 1'b1;
    addr = ~a;
    repeat (4) @(negedge clock);
  endtask : io_read
endmodule : io_host

// ---- bench/serial_port_io_decode_tb.sv ----
// self-checking bench for the four-port serial decode block
module serial_port_io_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock;
  logic rst;
  logic [7:0] addr;
  logic rd_n;
  logic wr_n;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic data_oe;
  logic [7:0] select_n;
  logic [7:0] cfg_switch;
  logic cts;
  logic dsr;
  logic dcd;
  logic ri;
  logic rxd;
  logic rxd_drv;
  logic loop_en;
  logic txd;
  logic rts;
  logic dtr;
  logic [7:0] control_shadow_copy;
  int err_total;
  int checked;
  int cycles;

  // loopback turns the block into its own far end on the wire
  assign rxd = loop_en ? txd : rxd_drv;

  serial_port_io_decode u_dut (.clock(clock), .rst(rst), .addr(addr),
    .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .select_n(select_n), .cfg_switch(cfg_switch),
    .cts(cts), .dsr(dsr), .dcd(dcd), .ri(ri), .rxd(rxd), .txd(txd),
    .rts(rts), .dtr(dtr));

  io_host u_host (.clock(clock), .addr(addr), .rd_n(rd_n), .wr_n(wr_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .select_n(select_n));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // one frame at 19200 is about 22000 cycles; the rest is short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      err_total = err_total + 1;
    end
  endtask : chk

  task automatic t_reset();
    chk("select_n", 8'hff, select_n);
    chk("txd", 8'h01, {7'h00, txd});
    chk("rts dtr", 8'h00, {6'h00, rts, dtr});
    chk("data_oe", 8'h00, {7'h00, data_oe});
  endtask : t_reset

  task automatic t_modem();
    logic [7:0] d;
    logic [7:0] s;
    logic oe;
    u_host.io_write(8'he8, 8'h5c, s);
    chk("reset select", 8'hef, s);
    cts = 1'b1;
    dsr = 1'b0;
    dcd = 1'b1;
    ri = 1'b0;
    rxd_drv = 1'b1;
    u_host.io_read(8'he8, d, s, oe);
    chk("modem status", 8'ha2, d);
    chk("modem select", 8'hfe, s);
    chk("modem oe", 8'h01, {7'h00, oe});
    cts = 1'b0;
    dsr = 1'b1;
    dcd = 1'b0;
    ri = 1'b1;
    rxd_drv = 1'b0;
    u_host.io_read(8'he8, d, s, oe);
    chk("modem status", 8'h50, d);
    rxd_drv = 1'b1;
  endtask : t_modem

  task automatic t_switch();
    logic [7:0] d;
    logic [7:0] s;
    logic oe;
    cfg_switch = 8'h5a;
    u_host.io_read(8'he9, d, s, oe);
    chk("switches", 8'h5a, d);
    chk("switch select", 8'hfd, s);
    cfg_switch = 8'ha5;
    u_host.io_read(8'he9, d, s, oe);
    chk("switches", 8'ha5, d);
  endtask : t_switch

  task automatic t_handshake();
    logic [7:0] d;
    logic [7:0] s;
    logic oe;
    // read-modify-write of the shadow, the port cannot be read back
    control_shadow_copy = 8'h07;
    u_host.io_write(8'hea, control_shadow_copy, s);
    chk("ctrl select", 8'hbf, s);
    chk("rts dtr txd", 8'h07, {5'h00, txd, rts, dtr});
    control_shadow_copy = control_shadow_copy & 8'hfb;
    u_host.io_write(8'hea, control_shadow_copy, s);
    chk("break txd", 8'h03, {5'h00, txd, rts, dtr});
    control_shadow_copy = control_shadow_copy & 8'hfe;
    u_host.io_write(8'hea, control_shadow_copy, s);
    chk("dtr off", 8'h02, {5'h00, txd, rts, dtr});
    control_shadow_copy = 8'h04;
    u_host.io_write(8'hea, control_shadow_copy, s);
    chk("rts off", 8'h04, {5'h00, txd, rts, dtr});
    u_host.io_read(8'hea, d, s, oe);
    chk("idle status", 8'h40, d);
    chk("status select", 8'hfb, s);
  endtask : t_handshake

  task automatic t_unmapped();
    logic [7:0] d;
    logic [7:0] s;
    logic oe;
    logic [7:0] outside [4] = '{8'he7, 8'hec, 8'h68, 8'hfb};
    foreach (outside[i]) begin
      u_host.io_read(outside[i], d, s, oe);
      chk("unmapped oe", 8'h00, {7'h00, oe});
      chk("unmapped select", 8'hff, s);
    end
  endtask : t_unmapped

  // start bit width and sample points follow 256 reference ticks a bit
  task automatic watch_wire();
    int n;
    n = 0;
    @(negedge txd);
    while (txd === 1'b0 && n < 3000) begin
      @(posedge clock);
      n = n + 1;
    end
    chk("start width ok", 8'h01, {7'h00, n >= 1990 && n <= 2050});
    repeat (1010) @(posedge clock);
    chk("first data bit", 8'h01, {7'h00, txd});
    repeat (8 * 2020) @(posedge clock);
    chk("even parity bit", 8'h00, {7'h00, txd});
    repeat (2020) @(posedge clock);
    chk("stop bit", 8'h01, {7'h00, txd});
  endtask : watch_wire

  task automatic t_loop();
    logic [7:0] d;
    logic [7:0] s;
    logic oe;
    int tries;
    loop_en = 1'b1;
    u_host.io_write(8'he9, 8'hff, s);
    chk("rate select", 8'hdf, s);
    control_shadow_copy = 8'he7;
    u_host.io_write(8'hea, control_shadow_copy, s);
    u_host.io_read(8'hea, d, s, oe);
    chk("holding empty", 8'h40, d & 8'h40);
    fork
      u_host.io_write(8'heb, 8'h35, s);
      watch_wire();
    join
    chk("char select", 8'h7f, s);
    tries = 0;
    d = 8'h00;
    while (d[7] !== 1'b1 && tries < 400) begin
      u_host.io_read(8'hea, d, s, oe);
      tries = tries + 1;
    end
    chk("ready no errors", 8'h80, d & 8'hb8);
    u_host.io_read(8'heb, d, s, oe);
    chk("received char", 8'h35, d);
    u_host.io_read(8'hea, d, s, oe);
    chk("ready cleared", 8'h00, d & 8'h80);
  endtask : t_loop

  initial begin
    err_total = 0;
    checked = 0;
    rst = 1'b1;
    cfg_switch = 8'hff;
    cts = 1'b0;
    dsr = 1'b0;
    dcd = 1'b0;
    ri = 1'b0;
    rxd_drv = 1'b1;
    loop_en = 1'b0;
    control_shadow_copy = 8'h04;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_reset();
    repeat (4) @(negedge clock);
    t_modem();
    t_switch();
    t_handshake();
    t_unmapped();
    t_loop();
    end_sim();
  end
endmodule : serial_port_io_decode_tb

// ---- rtl/rate_divider.sv ----
// one sixteen-times bit clock enable divided from the reference tick
`include "serial_port_regs.svh"
module rate_divider (
  input wire logic clock,
  input wire logic rst,
  input wire logic ref_tick,
  input wire logic [3:0] rate_code,
  output logic tick
);
  serial_port_pkg::div_state_s st_reg, st_next;

  function automatic logic [12:0] divisor(input logic [3:0] code);
    logic [12:0] d;
    d = `DIV_0;
    unique case (code)
      4'h0: d = `DIV_0;
      4'h1: d = `DIV_1;
      4'h2: d = `DIV_2;
      4'h3: d = `DIV_3;
      4'h4: d = `DIV_4;
      4'h5: d = `DIV_5;
      4'h6: d = `DIV_6;
      4'h7: d = `DIV_7;
      4'h8: d = `DIV_8;
      4'h9: d = `DIV_9;
      4'ha: d = `DIV_A;
      4'hb: d = `DIV_B;
      4'hc: d = `DIV_C;
      4'hd: d = `DIV_D;
      4'he: d = `DIV_E;
      4'hf: d = `DIV_F;
    endcase
    return d;
  endfunction : divisor

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (ref_tick) begin
      // >= so a rate change mid-count cannot overrun
      if (st_reg.cnt >= divisor(rate_code) - 13'h0001) begin
        st_next.cnt = 13'h0000;
        st_next.tick = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 13'h0001;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

  a_tick_spacing: assert property (@(posedge clock) disable iff (rst)
    st_reg.tick |=> !st_reg.tick)
    else $error("bit clock enable lasted more than one cycle");
endmodule : rate_divider

// ---- rtl/serial_port_io_decode.sv ----
// four-port decode, control latches and serial engine of the serial port
// Notes on behaviour
// - answers only ports e8 through eb
// - port chosen by low address byte qualified by active-low strobe
// - eight active-low selects, one per port and direction
// - any write to e8 resets the serial engine, data ignored
// - e8 read gives cts, dsr, carrier, ring in bits 7 to 4
// - e8 read gives raw receive line on bit 1, others zero
// - e9 write: high nibble transmit rate, low nibble receive rate
// - nibble codes 0 to f pick 50 up to 19200 baud
// - bit clocks are sixteen times the rate from 5.0688 mhz reference
// - switches carry baud, parity enable, stop count and parity sense
// - two switches select five to eight data bits
// - ea write loads frame control bits 7-3 and handshake bits 2-0
// - even parity, word length, two stops and parity inhibit fields
// - bit 2 clear forces break, bit 1 rts, bit 0 dtr
// - ea read: ready, holding empty, overrun, framing, parity
// - eb write loads the transmit holding register
// - eb read returns received character and clears ready
// - five to eight bits, optional parity, one, one and a half or two stops
`include "serial_port_regs.svh"
module serial_port_io_decode (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic [7:0] select_n,
  input wire logic [7:0] cfg_switch,
  input wire logic cts,
  input wire logic dsr,
  input wire logic dcd,
  input wire logic ri,
  input wire logic rxd,
  output logic txd,
  output logic rts,
  output logic dtr
);
  serial_port_pkg::port_state_s st_reg, st_next;
  serial_port_pkg::pins_s pins_now;
  logic tx_tick;
  logic rx_tick;

  // one-hot port hit, zero outside e8..eb
  function automatic logic [3:0] port_hit(input logic [7:0] a);
    logic [3:0] h;
    h = 4'h0;
    if (a[7:2] == 6'(`PORT_BASE >> 2)) begin
      h[a[1:0]] = 1'b1;
    end
    return h;
  endfunction : port_hit

  assign pins_now = '{addr: addr, data: data_in, rd_n: rd_n, wr_n: wr_n,
    cfg: cfg_switch, cts: cts, dsr: dsr, dcd: dcd, ri: ri, rxd: rxd};

  rate_divider tx_div (
    .clock(clock),
    .rst(rst),
    .ref_tick(st_reg.ref_tick),
    .rate_code(st_reg.rate[7:4]),
    .tick(tx_tick)
  );

  rate_divider rx_div (
    .clock(clock),
    .rst(rst),
    .ref_tick(st_reg.ref_tick),
    .rate_code(st_reg.rate[3:0]),
    .tick(rx_tick)
  );

  always_comb begin
    logic [3:0] hit;
    logic wr_fall;
    logic rd_rise;
    logic rd_on;
    logic [2:0] last_bit;
    logic par_on;
    logic even;
    logic [5:0] stop_len;
    logic [19:0] acc_sum;
    hit = 4'h0;
    wr_fall = 1'b0;
    rd_rise = 1'b0;
    rd_on = 1'b0;
    last_bit = 3'h0;
    par_on = 1'b0;
    even = 1'b0;
    stop_len = `STOP_ONE_TICKS;
    acc_sum = 20'h00000;
    st_next = st_reg;
    // pins cross into the clock domain through two flops
    st_next.s1 = pins_now;
    st_next.s2 = st_reg.s1;
    st_next.rd_prev_n = st_reg.s2.rd_n;
    st_next.wr_prev_n = st_reg.s2.wr_n;
    // 5.0688 mhz reference as fractional enable
    acc_sum = {1'b0, st_reg.ref_acc} + 20'(`REF_STEP);
    st_next.ref_tick = acc_sum >= 20'(`REF_MOD);
    st_next.ref_acc = st_next.ref_tick ? 19'(acc_sum - 20'(`REF_MOD))
                                       : acc_sum[18:0];
    hit = port_hit(st_reg.s2.addr);
    rd_on = !st_reg.s2.rd_n;
    wr_fall = !st_reg.s2.wr_n && st_reg.wr_prev_n;
    rd_rise = st_reg.s2.rd_n && !st_reg.rd_prev_n;
    if (!st_reg.s2.rd_n && st_reg.rd_prev_n) begin
      st_next.rd_addr = st_reg.s2.addr;
    end
    st_next.sel_n = ~({hit & {4{!st_reg.s2.wr_n}}, hit & {4{rd_on}}});
    // frame format from the control latch
    even = st_reg.ctrl[`CTRL_EVEN_BIT];
    par_on = !st_reg.ctrl[`CTRL_PAR_INH_BIT];
    last_bit = 3'h4 + {1'b0, st_reg.ctrl[`CTRL_WL_HI:`CTRL_WL_LO]};
    if (st_reg.ctrl[`CTRL_TWO_STOP_BIT]) begin
      stop_len = (last_bit == 3'h4) ? `STOP_ONE_HALF_TICKS : `STOP_TWO_TICKS;
    end
    // registered read data
    st_next.dout_oe = rd_on && (hit != 4'h0);
    st_next.dout = 8'h00;
    if (rd_on) begin
      unique case (1'b1)
        hit[`IDX_MODEM_RESET]: st_next.dout = {st_reg.s2.cts, st_reg.s2.dsr,
          st_reg.s2.dcd, st_reg.s2.ri, 2'b00, st_reg.s2.rxd, 1'b0};
        // raw switch byte, open reads one
        hit[`IDX_RATE_SWITCH]: st_next.dout = st_reg.s2.cfg;
        hit[`IDX_CTRL_STATUS]: st_next.dout = {st_reg.dr, !st_reg.thr_full,
          st_reg.ovr, st_reg.fe, st_reg.pe, 3'b000};
        hit[`IDX_CHAR]: st_next.dout = st_reg.rx_data;
        default: st_next.dout = 8'h00;
      endcase
    end
    // ready clears at the end of a character read
    if (rd_rise && port_hit(st_reg.rd_addr) == 4'h8) begin
      st_next.dr = 1'b0;
    end
    if (wr_fall) begin
      if (hit[`IDX_RATE_SWITCH]) st_next.rate = st_reg.s2.data;
      if (hit[`IDX_CTRL_STATUS]) st_next.ctrl = st_reg.s2.data;
      if (hit[`IDX_CHAR]) begin
        st_next.thr = st_reg.s2.data;
        st_next.thr_full = 1'b1;
      end
    end
    // transmitter
    unique case (st_reg.tx_st)
      serial_port_pkg::TX_IDLE: begin
        st_next.txd_raw = 1'b1;
        // launch on a bit clock so the start bit is a whole sixteen ticks
        if (st_reg.thr_full && tx_tick) begin
          st_next.tx_shift = st_reg.thr;
          st_next.thr_full = st_next.thr_full && wr_fall && hit[3];
          st_next.tx_st = serial_port_pkg::TX_START;
          st_next.tx_cnt = 6'h00;
          st_next.tx_bit = 3'h0;
          st_next.tx_par = 1'b0;
          st_next.txd_raw = 1'b0;
        end
      end
      serial_port_pkg::TX_START: if (tx_tick) begin
        st_next.tx_cnt = st_reg.tx_cnt + 6'h01;
        if (st_reg.tx_cnt == 6'h0f) begin
          st_next.tx_cnt = 6'h00;
          st_next.tx_st = serial_port_pkg::TX_DATA;
          st_next.txd_raw = st_reg.tx_shift[0];
        end
      end
      serial_port_pkg::TX_DATA: if (tx_tick) begin
        st_next.tx_cnt = st_reg.tx_cnt + 6'h01;
        if (st_reg.tx_cnt == 6'h0f) begin
          // lsb first, then parity, then stop
          st_next.tx_cnt = 6'h00;
          st_next.tx_par = st_reg.tx_par ^ st_reg.tx_shift[0];
          st_next.tx_shift = {1'b0, st_reg.tx_shift[7:1]};
          st_next.tx_bit = st_reg.tx_bit + 3'h1;
          st_next.txd_raw = st_reg.tx_shift[1];
          if (st_reg.tx_bit == last_bit) begin
            // even bit set gives even parity
            st_next.tx_st = par_on ? serial_port_pkg::TX_PAR
                                   : serial_port_pkg::TX_STOP;
            st_next.txd_raw = par_on ? (st_next.tx_par ^ !even) : 1'b1;
          end
        end
      end
      serial_port_pkg::TX_PAR: if (tx_tick) begin
        st_next.tx_cnt = st_reg.tx_cnt + 6'h01;
        if (st_reg.tx_cnt == 6'h0f) begin
          st_next.tx_cnt = 6'h00;
          st_next.tx_st = serial_port_pkg::TX_STOP;
          st_next.txd_raw = 1'b1;
        end
      end
      serial_port_pkg::TX_STOP: if (tx_tick) begin
        st_next.tx_cnt = st_reg.tx_cnt + 6'h01;
        if (st_reg.tx_cnt >= stop_len - 6'h01) begin
          st_next.tx_st = serial_port_pkg::TX_IDLE;
        end
      end
      default: st_next.tx_st = serial_port_pkg::TX_IDLE;
    endcase
    // receiver, mid-bit sampling
    unique case (st_reg.rx_st)
      serial_port_pkg::RX_IDLE: if (rx_tick && !st_reg.s2.rxd) begin
        st_next.rx_st = serial_port_pkg::RX_START;
        st_next.rx_cnt = 4'h0;
        st_next.rx_bit = 3'h0;
        st_next.rx_par = 1'b0;
      end
      serial_port_pkg::RX_START: if (rx_tick) begin
        st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
        // a start shorter than half a bit is noise
        if (st_reg.rx_cnt == 4'h7) begin
          st_next.rx_cnt = 4'h0;
          st_next.rx_st = st_reg.s2.rxd ? serial_port_pkg::RX_IDLE
                                        : serial_port_pkg::RX_DATA;
        end
      end
      serial_port_pkg::RX_DATA: if (rx_tick) begin
        st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
        if (st_reg.rx_cnt == 4'hf) begin
          st_next.rx_shift = {st_reg.s2.rxd, st_reg.rx_shift[7:1]};
          st_next.rx_par = st_reg.rx_par ^ st_reg.s2.rxd;
          st_next.rx_bit = st_reg.rx_bit + 3'h1;
          if (st_reg.rx_bit == last_bit) begin
            st_next.rx_st = par_on ? serial_port_pkg::RX_PAR
                                   : serial_port_pkg::RX_STOP;
          end
        end
      end
      serial_port_pkg::RX_PAR: if (rx_tick) begin
        st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
        if (st_reg.rx_cnt == 4'hf) begin
          st_next.rx_par = st_reg.rx_par ^ st_reg.s2.rxd;
          st_next.rx_st = serial_port_pkg::RX_STOP;
        end
      end
      serial_port_pkg::RX_STOP: if (rx_tick) begin
        st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
        if (st_reg.rx_cnt == 4'hf) begin
          // only the first stop bit is checked; load wins over clear
          st_next.rx_data = st_reg.rx_shift >> (3'h7 - last_bit);
          st_next.ovr = st_reg.dr && st_next.dr;
          st_next.dr = 1'b1;
          st_next.fe = !st_reg.s2.rxd;
          st_next.pe = par_on && (st_reg.rx_par ^ !even);
          st_next.rx_st = serial_port_pkg::RX_IDLE;
        end
      end
      default: st_next.rx_st = serial_port_pkg::RX_IDLE;
    endcase
    if (wr_fall && hit[`IDX_MODEM_RESET]) begin
      st_next.tx_st = serial_port_pkg::TX_IDLE;
      st_next.rx_st = serial_port_pkg::RX_IDLE;
      st_next.thr_full = 1'b0;
      st_next.txd_raw = 1'b1;
      st_next.dr = 1'b0;
      st_next.ovr = 1'b0;
      st_next.fe = 1'b0;
      st_next.pe = 1'b0;
    end
    st_next.txd = st_reg.txd_raw & st_reg.ctrl[`HS_TX_ENABLE_BIT];
    st_next.rts = st_reg.ctrl[`HS_RTS_BIT];
    st_next.dtr = st_reg.ctrl[`HS_DTR_BIT];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '{s1: '1, s2: '1, rd_prev_n: 1'b1, wr_prev_n: 1'b1,
        rd_addr: 8'h00, ref_acc: 19'h00000, ref_tick: 1'b0,
        ctrl: `CTRL_RESET, rate: `RATE_RESET, sel_n: 8'hff, dout: 8'h00,
        dout_oe: 1'b0, tx_st: serial_port_pkg::TX_IDLE, tx_cnt: 6'h00,
        tx_bit: 3'h0, tx_shift: 8'h00, tx_par: 1'b0, thr: 8'h00,
        thr_full: 1'b0, txd_raw: 1'b1, txd: 1'b1, rts: 1'b0, dtr: 1'b0,
        rx_st: serial_port_pkg::RX_IDLE, rx_cnt: 4'h0, rx_bit: 3'h0,
        rx_shift: 8'h00, rx_par: 1'b0, rx_data: 8'h00, dr: 1'b0,
        ovr: 1'b0, fe: 1'b0, pe: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign data_out = st_reg.dout;
  assign data_oe = st_reg.dout_oe;
  assign select_n = st_reg.sel_n;
  assign txd = st_reg.txd;
  assign rts = st_reg.rts;
  assign dtr = st_reg.dtr;

  a_sel_range: assert property (@(posedge clock) disable iff (rst)
    (select_n != 8'hff) |-> ($past(st_reg.s2.addr) >= 8'he8 &&
    $past(st_reg.s2.addr) <= 8'heb))
    else $error("select asserted outside the four ports");
  a_sel_onehot: assert property (@(posedge clock) disable iff (rst)
    $onehot0(~select_n))
    else $error("more than one select low");
  a_sel_strobe: assert property (@(posedge clock) disable iff (rst)
    (select_n[3:0] != 4'hf) |-> !$past(st_reg.s2.rd_n))
    else $error("read select without read strobe");
  a_reset_engine: assert property (@(posedge clock) disable iff (rst)
    (!st_reg.s2.wr_n && st_reg.wr_prev_n && st_reg.s2.addr == 8'he8)
    |=> (!st_reg.thr_full && !st_reg.dr
    && st_reg.tx_st == serial_port_pkg::TX_IDLE))
    else $error("engine not reset by port write");
  a_rate_load: assert property (@(posedge clock) disable iff (rst)
    (!st_reg.s2.wr_n && st_reg.wr_prev_n && st_reg.s2.addr == 8'he9)
    |=> st_reg.rate == $past(st_reg.s2.data))
    else $error("rate nibbles not loaded");
  // read data is registered from the same edge as the selects
  a_modem_read: assert property (@(posedge clock) disable iff (rst)
    (!select_n[0]) |-> (data_out[3:2] == 2'b00 && !data_out[0]
    && data_out[1] == $past(st_reg.s2.rxd)))
    else $error("modem status read wrong");
  a_switch_read: assert property (@(posedge clock) disable iff (rst)
    (!select_n[1]) |-> (data_oe && data_out == $past(st_reg.s2.cfg)))
    else $error("switch read does not match inputs");
  a_break_line: assert property (@(posedge clock) disable iff (rst)
    !st_reg.ctrl[`HS_TX_ENABLE_BIT] |=> !txd)
    else $error("transmit line not held low in break");
  a_start_low: assert property (@(posedge clock) disable iff (rst)
    (st_reg.tx_st == serial_port_pkg::TX_IDLE && st_reg.thr_full
    && tx_tick && st_reg.ctrl[`HS_TX_ENABLE_BIT]) |=> ##1 !txd)
    else $error("frame did not begin with low start bit");
endmodule : serial_port_io_decode

// ---- rtl/serial_port_pkg.sv ----
// types shared by the serial port decode and its rate dividers
package serial_port_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    rx_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic rd_n;
    logic wr_n;
    logic [7:0] cfg;
    logic cts;
    logic dsr;
    logic dcd;
    logic ri;
    logic rxd;
  } pins_s;
  typedef struct packed {
    logic [12:0] cnt;
    logic tick;
  } div_state_s;
  typedef struct packed {
    pins_s s1;
    pins_s s2;
    logic rd_prev_n;
    logic wr_prev_n;
    logic [7:0] rd_addr;
    logic [18:0] ref_acc;
    logic ref_tick;
    logic [7:0] ctrl;
    logic [7:0] rate;
    logic [7:0] sel_n;
    logic [7:0] dout;
    logic dout_oe;
    tx_state_e tx_st;
    logic [5:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_par;
    logic [7:0] thr;
    logic thr_full;
    logic txd_raw;
    logic txd;
    logic rts;
    logic dtr;
    rx_state_e rx_st;
    logic [3:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_par;
    logic [7:0] rx_data;
    logic dr;
    logic ovr;
    logic fe;
    logic pe;
  } port_state_s;
endpackage : serial_port_pkg

// ---- rtl/serial_port_regs.svh ----
// offsets, bit positions, reset values and timing counts of the serial port
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
`define PORT_BASE 8'he8
`define PORT_MODEM_RESET 8'he8
`define PORT_RATE_SWITCH 8'he9
`define PORT_CTRL_STATUS 8'hea
`define PORT_CHAR 8'heb
`define IDX_MODEM_RESET 2'h0
`define IDX_RATE_SWITCH 2'h1
`define IDX_CTRL_STATUS 2'h2
`define IDX_CHAR 2'h3
`define CTRL_EVEN_BIT 7
`define CTRL_WL_HI 6
`define CTRL_WL_LO 5
`define CTRL_TWO_STOP_BIT 4
`define CTRL_PAR_INH_BIT 3
`define HS_TX_ENABLE_BIT 2
`define HS_RTS_BIT 1
`define HS_DTR_BIT 0
`define CTRL_RESET 8'h04
`define RATE_RESET 8'h22
`define CLK_HZ 40000000
`define REF_HZ 5068800
`define REF_STEP (`REF_HZ / 100)
`define REF_MOD (`CLK_HZ / 100)
`define OVERSAMPLE 16
`define STOP_ONE_TICKS 6'h10
`define STOP_ONE_HALF_TICKS 6'h18
`define STOP_TWO_TICKS 6'h20
`define DIV_0 13'h18c0
`define DIV_1 13'h1080
`define DIV_2 13'h0b40
`define DIV_3 13'h0933
`define DIV_4 13'h0840
`define DIV_5 13'h0420
`define DIV_6 13'h0210
`define DIV_7 13'h0108
`define DIV_8 13'h00b0
`define DIV_9 13'h009e
`define DIV_A 13'h0084
`define DIV_B 13'h0058
`define DIV_C 13'h0042
`define DIV_D 13'h002c
`define DIV_E 13'h0021
`define DIV_F 13'h0010
`endif
